// ### rtl/pmbus_status_flag_bank.sv
// Purpose: Warning and fault flag bank behind a PMBus command decoder
// Assumes: Protocol engine and limit comparators run on i_clk
// Notes: Latched flags feed the open-drain alert line
//
// What this block does
// - Input below threshold sets undervoltage flags, alert
// - Zero threshold disables compare; resets zero
// - Summary byte bit 3 reports undervoltage
// - Summary bit 2 reports temperature flags
// - Summary bit 1 reports communication fault
// - Summary bit 0 other faults, resets 1
// - Word bit 13 input fault; low byte
// - Word bit 12 vendor flags, resets 1
// - Word input summary bits 13 and 3 read 1 at startup
// - Latched bits clear: condition gone plus clear
// - Input byte bit 6 overvoltage warning
// - Input byte bit 5 undervoltage warning
// - Input bit 1 overcurrent, bit 0 overpower
// - Temperature byte bit 7 overtemperature fault
// - Temperature byte bit 6 overtemperature warning
// - Communication bit 7 invalid command code
// - Communication bit 6 invalid data bytes
// - Communication bit 5 packet check mismatch
// - Communication bit 1 miscellaneous fault
// - Communication bits cleared by clear alone
// - Vendor byte bit 4 defaults loaded
// - Clear command resets flags, releases alert
// - Vendor bit 1 aux over, 0 under
`timescale 1ns/1ps
`include "pmbus_status_params.svh"

module pmbus_status_flag_bank
    import pmbus_status_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_code,
    input wire proto_t i_cmd_proto,
    input wire logic [15:0] i_wr_data,
    input wire logic i_pec_fail,
    input wire logic i_misc_fail,
    input wire logic i_input_voltage_valid,
    input wire logic [11:0] i_input_voltage,
    input wire logic i_input_overvoltage_warning,
    input wire logic i_input_overcurrent_warning,
    input wire logic i_input_overpower_warning,
    input wire logic i_ot_fault,
    input wire logic i_ot_warning,
    input wire logic i_auxiliary_overvoltage_warning,
    input wire logic i_auxiliary_undervoltage_warning,
    output logic [15:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_alert_line_o,
    output logic o_alert_line_oe
);

    bank_state_t state_reg;
    bank_state_t state_next;

    logic clear_cmd;
    logic known_code;
    logic proto_ok;
    logic is_read;
    logic uv_now;
    logic [7:0] input_byte;
    logic [7:0] temp_byte;
    logic [7:0] comm_byte;
    logic [7:0] vendor_byte;
    logic [7:0] summary_byte;
    logic [15:0] summary_word;
    logic any_input;
    logic any_vendor;
    logic [15:0] read_mux;

    ////////////////////////////////////////////////////////////////////////////
    // Command decode

    assign is_read = (i_cmd_proto == PROTO_READ_BYTE) ||
                     (i_cmd_proto == PROTO_READ_WORD);

    always_comb begin
        known_code = 1'b1;
        proto_ok = 1'b0;
        case (i_cmd_code)
            `CMD_CLEAR_FAULTS: begin
                proto_ok = (i_cmd_proto == PROTO_SEND_BYTE);
            end
            `CMD_UV_WARN_THR: begin
                proto_ok = (i_cmd_proto == PROTO_READ_WORD) ||
                           (i_cmd_proto == PROTO_WRITE_WORD);
            end
            `CMD_SUMMARY_WORD: begin
                proto_ok = (i_cmd_proto == PROTO_READ_WORD);
            end
            `CMD_SUMMARY_BYTE,
            `CMD_INPUT_FLAGS,
            `CMD_TEMP_FLAGS,
            `CMD_COMM_FLAGS,
            `CMD_VENDOR_FLAGS: begin
                proto_ok = (i_cmd_proto == PROTO_READ_BYTE);
            end
            default: begin
                known_code = 1'b0;
            end
        endcase
    end

    assign clear_cmd = i_cmd_valid && known_code && proto_ok &&
                       (i_cmd_code == `CMD_CLEAR_FAULTS);

    ////////////////////////////////////////////////////////////////////////////
    // Undervoltage compare

    assign uv_now = (state_reg.uv_thr != `UV_THR_DISABLED) &&
                    (i_input_voltage < state_reg.uv_thr);

    ////////////////////////////////////////////////////////////////////////////
    // Register images

    always_comb begin
        input_byte = 8'h00;
        temp_byte = 8'h00;
        comm_byte = 8'h00;
        vendor_byte = 8'h00;
        input_byte[`IN_OV_WARN_BIT] = state_reg.in_ov_warn;
        input_byte[`IN_UV_WARN_BIT] = state_reg.in_uv_warn;
        input_byte[`IN_OC_WARN_BIT] = state_reg.in_oc_warn;
        input_byte[`IN_OP_WARN_BIT] = state_reg.in_op_warn;
        temp_byte[`TEMP_OT_FAULT_BIT] = state_reg.ot_fault;
        temp_byte[`TEMP_OT_WARN_BIT] = state_reg.ot_warn;
        comm_byte[`COMM_BAD_CMD_BIT] = state_reg.bad_cmd;
        comm_byte[`COMM_BAD_DATA_BIT] = state_reg.bad_data;
        comm_byte[`COMM_PEC_BIT] = state_reg.pec_fail;
        comm_byte[`COMM_MISC_BIT] = state_reg.misc_fail;
        vendor_byte[`VEND_DEFAULTS_BIT] = state_reg.defaults_loaded;
        vendor_byte[`VEND_AUX_OV_BIT] = state_reg.aux_ov_warn;
        vendor_byte[`VEND_AUX_UV_BIT] = state_reg.aux_uv_warn;
    end

    assign any_input = (|input_byte) || state_reg.startup_input;
    assign any_vendor = |vendor_byte;

    always_comb begin
        summary_byte = 8'h00;
        summary_byte[`SUM_VIN_UV_BIT] = state_reg.in_uv_warn;
        summary_byte[`SUM_TEMP_BIT] = |temp_byte;
        summary_byte[`SUM_COMM_BIT] = |comm_byte;
        summary_byte[`SUM_OTHER_BIT] = state_reg.in_ov_warn ||
                                       state_reg.in_oc_warn ||
                                       state_reg.in_op_warn || any_vendor;
    end

    always_comb begin
        summary_word = {8'h00, summary_byte};
        summary_word[`WORD_INPUT_BIT] = any_input;
        summary_word[`WORD_VENDOR_BIT] = any_vendor;
        summary_word[`SUM_VIN_UV_BIT] = state_reg.in_uv_warn ||
                                        state_reg.startup_input;
    end

    always_comb begin
        case (i_cmd_code)
            `CMD_UV_WARN_THR: begin
                read_mux = {4'h0, state_reg.uv_thr};
            end
            `CMD_SUMMARY_BYTE: begin
                read_mux = {8'h00, summary_byte};
            end
            `CMD_SUMMARY_WORD: begin
                read_mux = summary_word;
            end
            `CMD_INPUT_FLAGS: begin
                read_mux = {8'h00, input_byte};
            end
            `CMD_TEMP_FLAGS: begin
                read_mux = {8'h00, temp_byte};
            end
            `CMD_COMM_FLAGS: begin
                read_mux = {8'h00, comm_byte};
            end
            `CMD_VENDOR_FLAGS: begin
                read_mux = {8'h00, vendor_byte};
            end
            default: begin
                read_mux = 16'h0000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        state_next = state_reg;
        state_next.rd_valid = 1'b0;

        if (i_input_voltage_valid) begin
            state_next.vin_low = uv_now;
        end

        if (clear_cmd) begin
            state_next.in_ov_warn = 1'b0;
            state_next.in_uv_warn = 1'b0;
            state_next.in_oc_warn = 1'b0;
            state_next.in_op_warn = 1'b0;
            state_next.ot_fault = 1'b0;
            state_next.ot_warn = 1'b0;
            state_next.aux_ov_warn = 1'b0;
            state_next.aux_uv_warn = 1'b0;
            state_next.defaults_loaded = 1'b0;
            state_next.startup_input = 1'b0;
            state_next.bad_cmd = 1'b0;
            state_next.bad_data = 1'b0;
            state_next.pec_fail = 1'b0;
            state_next.misc_fail = 1'b0;
        end

        if (state_reg.vin_low) begin
            state_next.in_uv_warn = 1'b1;
        end
        if (i_input_overvoltage_warning) begin
            state_next.in_ov_warn = 1'b1;
        end
        if (i_input_overcurrent_warning) begin
            state_next.in_oc_warn = 1'b1;
        end
        if (i_input_overpower_warning) begin
            state_next.in_op_warn = 1'b1;
        end
        if (i_ot_fault) begin
            state_next.ot_fault = 1'b1;
        end
        if (i_ot_warning) begin
            state_next.ot_warn = 1'b1;
        end
        if (i_auxiliary_overvoltage_warning) begin
            state_next.aux_ov_warn = 1'b1;
        end
        if (i_auxiliary_undervoltage_warning) begin
            state_next.aux_uv_warn = 1'b1;
        end

        // Communication events win over a same-cycle clear
        if (i_pec_fail) begin
            state_next.pec_fail = 1'b1;
        end
        if (i_misc_fail) begin
            state_next.misc_fail = 1'b1;
        end

        if (i_cmd_valid) begin
            if (!known_code) begin
                state_next.bad_cmd = 1'b1;
            end else if (!proto_ok) begin
                state_next.bad_data = 1'b1;
            end else if ((i_cmd_code == `CMD_UV_WARN_THR) &&
                         (i_cmd_proto == PROTO_WRITE_WORD)) begin
                // Out-of-range word is refused and flagged
                if (i_wr_data > `UV_THR_MAX) begin
                    state_next.bad_data = 1'b1;
                end else begin
                    state_next.uv_thr = i_wr_data[11:0];
                end
            end
            if (is_read) begin
                state_next.rd_valid = 1'b1;
                state_next.rd_data = (known_code && proto_ok) ? read_mux : 16'h0000;
            end
        end

        state_next.alert = state_next.in_ov_warn || state_next.in_uv_warn ||
                           state_next.in_oc_warn || state_next.in_op_warn ||
                           state_next.ot_fault || state_next.ot_warn ||
                           state_next.bad_cmd || state_next.bad_data ||
                           state_next.pec_fail || state_next.misc_fail ||
                           state_next.aux_ov_warn || state_next.aux_uv_warn;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= '0;
            state_reg.uv_thr <= `UV_THR_RESET;
            state_reg.defaults_loaded <= `DEFAULTS_LOADED_RESET;
            state_reg.startup_input <= `STARTUP_INPUT_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_rd_data = state_reg.rd_data;
    assign o_rd_valid = state_reg.rd_valid;
    // Open-drain: only ever pulls low
    assign o_alert_line_o = 1'b0;
    assign o_alert_line_oe = state_reg.alert;

endmodule // pmbus_status_flag_bank

// ### rtl/pmbus_status_params.svh
// Purpose: Command codes, bit positions and reset values of the status bank
// Assumes: Included once per compile unit
// Notes: Guarded against double inclusion
`ifndef PMBUS_STATUS_PARAMS_SVH
`define PMBUS_STATUS_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Command codes
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_UV_WARN_THR 8'h58
`define CMD_SUMMARY_BYTE 8'h78
`define CMD_SUMMARY_WORD 8'h79
`define CMD_INPUT_FLAGS 8'h7c
`define CMD_TEMP_FLAGS 8'h7d
`define CMD_COMM_FLAGS 8'h7e
`define CMD_VENDOR_FLAGS 8'h80

////////////////////////////////////////////////////////////////////////////////
// Threshold limits and reset value
`define UV_THR_RESET 12'h000
`define UV_THR_DISABLED 12'h000
`define UV_THR_MAX 16'h0fff

////////////////////////////////////////////////////////////////////////////////
// Summary byte and word bits
`define SUM_VIN_UV_BIT 3
`define SUM_TEMP_BIT 2
`define SUM_COMM_BIT 1
`define SUM_OTHER_BIT 0
`define WORD_INPUT_BIT 13
`define WORD_VENDOR_BIT 12

////////////////////////////////////////////////////////////////////////////////
// Detailed register bits
`define IN_OV_WARN_BIT 6
`define IN_UV_WARN_BIT 5
`define IN_OC_WARN_BIT 1
`define IN_OP_WARN_BIT 0
`define TEMP_OT_FAULT_BIT 7
`define TEMP_OT_WARN_BIT 6
`define COMM_BAD_CMD_BIT 7
`define COMM_BAD_DATA_BIT 6
`define COMM_PEC_BIT 5
`define COMM_MISC_BIT 1
`define VEND_DEFAULTS_BIT 4
`define VEND_AUX_OV_BIT 1
`define VEND_AUX_UV_BIT 0

////////////////////////////////////////////////////////////////////////////////
// Flag values at reset
`define DEFAULTS_LOADED_RESET 1'b1
`define STARTUP_INPUT_RESET 1'b1

`endif

// ### rtl/pmbus_status_pkg.sv
// Purpose: Types shared by the status bank and its command port
// Assumes: Numbers live in pmbus_status_params.svh
// Notes: Protocol codes name the SMBus transaction carrying a command
package pmbus_status_pkg;

    typedef enum logic [2:0] {
        PROTO_SEND_BYTE = 3'b000,
        PROTO_WRITE_BYTE = 3'b001,
        PROTO_WRITE_WORD = 3'b010,
        PROTO_READ_BYTE = 3'b011,
        PROTO_READ_WORD = 3'b100
    } proto_t;

    typedef struct packed {
        logic [11:0] uv_thr;
        logic vin_low;
        logic in_ov_warn;
        logic in_uv_warn;
        logic in_oc_warn;
        logic in_op_warn;
        logic ot_fault;
        logic ot_warn;
        logic bad_cmd;
        logic bad_data;
        logic pec_fail;
        logic misc_fail;
        logic defaults_loaded;
        logic startup_input;
        logic aux_ov_warn;
        logic aux_uv_warn;
        logic [15:0] rd_data;
        logic rd_valid;
        logic alert;
    } bank_state_t;

endpackage

// ### sim/pmbus_host_model.sv
// Purpose: Management host issuing decoded transactions
// Assumes: Requests launched just after a rising edge
// Notes: Released code and data fields show inverted values
`timescale 1ns/1ps
module pmbus_host_model
    import pmbus_status_pkg::*;
(
    input wire logic i_clk,
    input wire logic [15:0] i_rd_data,
    input wire logic i_rd_valid,
    output logic o_cmd_valid,
    output logic [7:0] o_cmd_code,
    output proto_t o_cmd_proto,
    output logic [15:0] o_wr_data
);
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_code = 8'h00;
        o_cmd_proto = PROTO_SEND_BYTE;
        o_wr_data = 16'h0000;
    end
    task automatic xfer(input logic [7:0] c, input proto_t p, input logic [15:0] d,
                        output logic [15:0] r, output logic v);
        @(posedge i_clk);
        o_cmd_valid <= 1'b1;
        o_cmd_code <= c;
        o_cmd_proto <= p;
        o_wr_data <= d;
        @(posedge i_clk);
        o_cmd_valid <= 1'b0;
        o_cmd_code <= ~c;
        o_wr_data <= ~d;
        // Answer is taken at the edge that samples its valid pulse
        @(posedge i_clk);
        v = i_rd_valid;
        r = i_rd_data;
        #1;
    endtask
endmodule // pmbus_host_model

// ### sim/pmbus_status_checker.sv
// Purpose: Port-level checks of the status flag bank
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to the bank below the module
`timescale 1ns/1ps
module pmbus_status_checker
    import pmbus_status_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_code,
    input wire proto_t i_cmd_proto,
    input wire logic i_pec_fail,
    input wire logic i_misc_fail,
    input wire logic i_ot_fault,
    input wire logic i_ot_warning,
    input wire logic [15:0] o_rd_data,
    input wire logic o_rd_valid,
    input wire logic o_alert_line_o,
    input wire logic o_alert_line_oe
);
    logic rd_req;
    logic clr_req;
    assign rd_req = i_cmd_valid && (i_cmd_proto inside {PROTO_READ_BYTE, PROTO_READ_WORD});
    assign clr_req = i_cmd_valid && i_cmd_code == 8'h03 && i_cmd_proto == PROTO_SEND_BYTE;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    sequence byte_read;
        i_cmd_valid && i_cmd_proto == PROTO_READ_BYTE;
    endsequence
    sequence clear_while_warm;
        i_ot_warning && clr_req;
    endsequence
    sequence kept_alert;
        o_alert_line_oe && !clr_req;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    read_answer_a: assert property (rd_req |=> o_rd_valid)
        else $error("read not answered");
    no_stray_a: assert property (!rd_req |=> !o_rd_valid)
        else $error("answer without read");
    data_hold_a: assert property (!rd_req |=> $stable(o_rd_data))
        else $error("read data moved");
    byte_upper_a: assert property (byte_read |=> o_rd_data[15:8] == 8'h00)
        else $error("byte read upper bits set");
    temp_fault_a: assert property (i_ot_fault |=> o_alert_line_oe)
        else $error("fault without alert");
    temp_warn_a: assert property (i_ot_warning |=> o_alert_line_oe)
        else $error("warning without alert");
    comm_event_a: assert property (i_pec_fail || i_misc_fail |=> o_alert_line_oe)
        else $error("comm event without alert");
    alert_latch_a: assert property (kept_alert |=> o_alert_line_oe)
        else $error("alert dropped without clear");
    clear_persist_a: assert property (clear_while_warm |=> o_alert_line_oe)
        else $error("alert dropped with condition");
    open_drain_a: assert property (o_alert_line_o == 1'b0)
        else $error("alert line driven high");
endmodule // pmbus_status_checker

bind pmbus_status_flag_bank pmbus_status_checker u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code), .i_cmd_proto(i_cmd_proto),
    .i_pec_fail(i_pec_fail), .i_misc_fail(i_misc_fail), .i_ot_fault(i_ot_fault),
    .i_ot_warning(i_ot_warning), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_alert_line_o(o_alert_line_o), .o_alert_line_oe(o_alert_line_oe));

// ### sim/pmbus_status_flag_bank_tb.sv
// Purpose: Self-checking bench of the status flag bank
// Assumes: Host model drives the command port
// Notes: Flags are cleared between scenarios
`timescale 1ns/1ps
module pmbus_status_flag_bank_tb;
    import pmbus_status_pkg::*;
    logic i_clk, i_rst_b, cmd_valid, pec, misc, vin_valid, rd_valid, alert_o, alert_oe;
    logic [7:0] cmd_code;
    proto_t cmd_proto;
    logic [15:0] wr_data, rd_data;
    logic [11:0] input_voltage;
    logic [6:0] cond;
    int errors, comparisons;
    logic [7:0] dcode [7] = '{8'h7c, 8'h7c, 8'h7c, 8'h7d, 8'h7d, 8'h80, 8'h80};
    logic [7:0] dval [7] = '{8'h40, 8'h02, 8'h01, 8'h80, 8'h40, 8'h02, 8'h01};
    logic [7:0] bval [7] = '{8'h01, 8'h01, 8'h01, 8'h04, 8'h04, 8'h01, 8'h01};
    logic [7:0] whi [7] = '{8'h20, 8'h20, 8'h20, 8'h00, 8'h00, 8'h10, 8'h10};

    pmbus_host_model u_host (.i_clk(i_clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
        .o_cmd_valid(cmd_valid),
        .o_cmd_code(cmd_code), .o_cmd_proto(cmd_proto), .o_wr_data(wr_data));
    pmbus_status_flag_bank u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cmd_valid(cmd_valid),
        .i_cmd_code(cmd_code), .i_cmd_proto(cmd_proto), .i_wr_data(wr_data),
        .i_pec_fail(pec), .i_misc_fail(misc), .i_input_voltage_valid(vin_valid),
        .i_input_voltage(input_voltage), .i_input_overvoltage_warning(cond[0]),
        .i_input_overcurrent_warning(cond[1]), .i_input_overpower_warning(cond[2]),
        .i_ot_fault(cond[3]), .i_ot_warning(cond[4]),
        .i_auxiliary_overvoltage_warning(cond[5]), .i_auxiliary_undervoltage_warning(cond[6]),
        .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_alert_line_o(alert_o),
        .o_alert_line_oe(alert_oe));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c, input proto_t p, input logic [15:0] d);
        logic [15:0] r;
        logic v;
        u_host.xfer(c, p, d, r, v);
    endtask
    task automatic rd(input logic [7:0] c, input proto_t p, input logic [15:0] exp);
        logic [15:0] r;
        logic v;
        u_host.xfer(c, p, 16'h0000, r, v);
        check({15'h0, v}, 16'h0001);
        check(r, exp);
    endtask
    task automatic clear;
        cmd(8'h03, PROTO_SEND_BYTE, 16'h0000);
    endtask
    task automatic vin_sample(input logic [11:0] v);
        @(posedge i_clk);
        input_voltage <= v;
        vin_valid <= 1'b1;
        @(posedge i_clk);
        vin_valid <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
    endtask
    task automatic final_report;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(8'h78, PROTO_READ_BYTE, 16'h0001);
        rd(8'h79, PROTO_READ_WORD, 16'h3009);
        rd(8'h80, PROTO_READ_BYTE, 16'h0010);
        rd(8'h58, PROTO_READ_WORD, 16'h0000);
        check({15'h0, alert_oe}, 16'h0000);
        clear;
        rd(8'h79, PROTO_READ_WORD, 16'h0000);
    endtask
    task automatic t_thr;
        cmd(8'h58, PROTO_WRITE_WORD, 16'h0fff);
        rd(8'h58, PROTO_READ_WORD, 16'h0fff);
        cmd(8'h58, PROTO_WRITE_WORD, 16'h1000);
        rd(8'h58, PROTO_READ_WORD, 16'h0fff);
        rd(8'h7e, PROTO_READ_BYTE, 16'h0040);
        rd(8'h78, PROTO_READ_BYTE, 16'h0002);
        clear;
        rd(8'h7e, PROTO_READ_BYTE, 16'h0000);
        cmd(8'h58, PROTO_WRITE_WORD, 16'h0800);
    endtask
    task automatic t_uv;
        vin_sample(12'h800);
        rd(8'h7c, PROTO_READ_BYTE, 16'h0000);
        vin_sample(12'h7ff);
        check({15'h0, alert_oe}, 16'h0001);
        rd(8'h7c, PROTO_READ_BYTE, 16'h0020);
        rd(8'h78, PROTO_READ_BYTE, 16'h0008);
        rd(8'h79, PROTO_READ_WORD, 16'h2008);
        clear;
        rd(8'h7c, PROTO_READ_BYTE, 16'h0020);
        vin_sample(12'h900);
        clear;
        rd(8'h79, PROTO_READ_WORD, 16'h0000);
        check({15'h0, alert_oe}, 16'h0000);
    endtask
    task automatic t_cond;
        for (int i = 0; i < 7; i++) begin
            @(posedge i_clk);
            cond <= 7'h01 << i;
            repeat (2) @(posedge i_clk);
            #1;
            check({15'h0, alert_oe}, 16'h0001);
            rd(dcode[i], PROTO_READ_BYTE, {8'h00, dval[i]});
            rd(8'h78, PROTO_READ_BYTE, {8'h00, bval[i]});
            rd(8'h79, PROTO_READ_WORD, {whi[i], bval[i]});
            clear;
            rd(dcode[i], PROTO_READ_BYTE, {8'h00, dval[i]});
            @(posedge i_clk);
            cond <= 7'h00;
            clear;
            rd(dcode[i], PROTO_READ_BYTE, 16'h0000);
        end
    endtask
    task automatic t_comm;
        rd(8'h20, PROTO_READ_BYTE, 16'h0000);
        rd(8'h7e, PROTO_READ_BYTE, 16'h0080);
        cmd(8'h78, PROTO_WRITE_BYTE, 16'h0000);
        rd(8'h7e, PROTO_READ_BYTE, 16'h00c0);
        @(posedge i_clk);
        pec <= 1'b1;
        @(posedge i_clk);
        pec <= 1'b0;
        misc <= 1'b1;
        @(posedge i_clk);
        misc <= 1'b0;
        rd(8'h7e, PROTO_READ_BYTE, 16'h00e2);
        rd(8'h78, PROTO_READ_BYTE, 16'h0002);
        clear;
        rd(8'h7e, PROTO_READ_BYTE, 16'h0000);
        check({15'h0, alert_oe}, 16'h0000);
    endtask
    task automatic t_rerun;
        @(posedge i_clk);
        cond <= 7'h08;
        i_rst_b <= 1'b0;
        @(posedge i_clk);
        cond <= 7'h00;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        rd(8'h79, PROTO_READ_WORD, 16'h3009);
        rd(8'h58, PROTO_READ_WORD, 16'h0000);
        rd(8'h7d, PROTO_READ_BYTE, 16'h0000);
        check({15'h0, alert_oe}, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        i_rst_b = 1'b0;
        pec = 1'b0;
        misc = 1'b0;
        vin_valid = 1'b0;
        input_voltage = 12'h000;
        cond = 7'h00;
        errors = 0;
        comparisons = 0;
        repeat (4) @(posedge i_clk);
        i_rst_b <= 1'b1;
        t_reset;
        t_thr;
        t_uv;
        t_cond;
        t_comm;
        t_rerun;
        final_report;
    end
    initial begin
        #100000;
        errors++;
        final_report;
    end
endmodule // pmbus_status_flag_bank_tb
